//--- smt_bus_partner.sv
// smt_bus_partner: far-side smbus party pulling scl and sda low
// assumes the bench resolves both wired lines with pull-ups
`timescale 1ns/1ps
module smt_bus_partner (
  // open-drain pulls, high holds the line low
  output logic scl_hold,
  output logic sda_hold
);
  initial begin
    scl_hold = 1'b0;
    sda_hold = 1'b0;
  end
  // a stuck or stretching slave simply keeps scl low
  task automatic hold_scl(input logic v);
    scl_hold = v;
  endtask : hold_scl
  task automatic hold_sda(input logic v);
    sda_hold = v;
  endtask : hold_sda
  // 160 ns scl, low phases stretched; scl stands still between frames
  task automatic clock_frame(input int bits, input int stretch_ns);
    #3;
    repeat (bits) begin
      scl_hold = 1'b1;
      #(80 + stretch_ns);
      scl_hold = 1'b0;
      #80;
    end
  endtask : clock_frame
endmodule : smt_bus_partner

//--- smt_pkg.sv
// smt_pkg: constants and types for the smbus timeout detector
// assumes a 50 MHz core clock; timer 2 ticks and clock-source ticks come from core logic
package smt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned HZ_PER_MHZ         = 1_000_000;
  localparam int unsigned SCL_LOW_TIMEOUT_US = 25_000;
  localparam int unsigned ABORT_DEADLINE_US  = 10_000;
  localparam int unsigned BUS_FREE_US        = 50;
  // least time: exact product, not rounded up
  localparam int unsigned SCL_LOW_TIMEOUT_CYC =
    (SCL_LOW_TIMEOUT_US * (CLK_HZ / HZ_PER_MHZ));
  // longest time: round down
  localparam int unsigned ABORT_DEADLINE_CYC =
    (ABORT_DEADLINE_US * (CLK_HZ / HZ_PER_MHZ));
  localparam int unsigned BUS_FREE_CYC = (BUS_FREE_US * (CLK_HZ / HZ_PER_MHZ));

  // ----------------------------------------------------------------
  // timer 2 and bus-free counter
  // ----------------------------------------------------------------
  localparam int unsigned T2_W       = 16;
  localparam logic [15:0] T2_MAX     = 16'hffff;
  localparam logic [15:0] T2_RST_VAL = 16'h0000;
  localparam int unsigned FREE_W     = 4;
  localparam logic [3:0]  FREE_LIMIT = 4'ha;   // free after more than this many periods
  localparam logic [3:0]  FREE_ONE   = 4'h1;
  localparam logic [3:0]  FREE_ZERO  = 4'h0;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_BUSY = 2'b01,
    BUS_FREE = 2'b10
  } smt_bus_t;

endpackage : smt_pkg

//--- smt_sync2.sv
// smt_sync2: two flip-flop level synchroniser
// assumes din is asynchronous to clk; only the second stage is visible
`timescale 1ns/1ps
module smt_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;

  // reset to 1: released open-drain lines idle high
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= 1'b1;
      dout    <= 1'b1;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : smt_sync2

//--- smt_timeout_detect.sv
// smt_timeout_detect: scl-low timeout via timer 2, bus-free timeout, scl release
// assumes the smbus engine, timer 2 tick and clock-source tick share core_clk
//
// Functional notes
// - a slave may hold scl low; high phase timing starts at real scl rise.
// - master only releases scl, never drives it high.
// - any scl low period over 25 ms is a timeout.
// - after a timeout, abandon bus communication within 10 ms.
// - scl-low timeout enable makes timer 2 the clock-low detector.
// - with timeout enabled, timer 2 reloads while scl high, counts while low.
// - timer 2 overflow raises its interrupt; software may reset the engine.
// - bus is free once scl and sda both stay high over 50 us.
// - with free timeout enabled, free after over 10 clock-source periods high.
// - a pending master start is issued as soon as the bus is free.
// - clock-source ticks are needed for bus-free detection, even slave-only.
`timescale 1ns/1ps
module smt_timeout_detect
  import smt_pkg::*;
#(
  parameter int unsigned ABORT_MAX_CYC = ABORT_DEADLINE_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // bus pins (open drain, oe low drives)
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  // configuration
  input  wire logic        scl_low_timeout_enable,
  input  wire logic        bus_free_timeout_enable,
  // timer 2
  input  wire logic        t2_run,
  input  wire logic        t2_tick,
  input  wire logic [15:0] t2_reload,
  input  wire logic        t2_irq_clear,
  output logic [15:0]      t2_count,
  output logic             t2_irq,
  // smbus engine
  input  wire logic        src_tick,
  input  wire logic        scl_drive_low,
  input  wire logic        start_pending,
  output logic             scl_rise,
  output logic             comm_abort,
  output logic             bus_free,
  output logic             start_go
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d_ff;
  logic sda_d_ff;

  smt_sync2 u_scl_sync (
    .clk  (core_clk),
    .srst (srst),
    .din  (scl_i),
    .dout (scl_s)
  );

  smt_sync2 u_sda_sync (
    .clk  (core_clk),
    .srst (srst),
    .din  (sda_i),
    .dout (sda_s)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic stop_seen;
  logic start_seen;
  assign stop_seen  = scl_s && scl_d_ff && sda_s && !sda_d_ff;
  assign start_seen = scl_s && scl_d_ff && !sda_s && sda_d_ff;

  // ----------------------------------------------------------------
  // scl drive and rise report
  // ----------------------------------------------------------------
  logic scl_o_ff;
  logic scl_oe_n_ff;
  logic scl_rise_ff;
  logic comm_abort_ff;

  // only ever pulls low; release is the only way up, so a stuck line needs the timeout
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_o_ff    <= 1'b0;
      scl_oe_n_ff <= 1'b1;
    end else begin
      scl_o_ff    <= 1'b0;
      scl_oe_n_ff <= !(scl_drive_low && !comm_abort_ff);
    end
  end

  // engine starts timing the high phase here, so a stretching slave slows the bit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_rise_ff <= 1'b0;
    end else begin
      scl_rise_ff <= scl_s && !scl_d_ff;
    end
  end

  // ----------------------------------------------------------------
  // timer 2 with scl-high reload
  // ----------------------------------------------------------------
  logic [15:0] t2_count_ff;
  logic        t2_irq_ff;
  logic        t2_hold;
  logic        t2_wrap;

  assign t2_hold = scl_low_timeout_enable && scl_s;
  assign t2_wrap = t2_run && t2_tick && !t2_hold && (t2_count_ff == T2_MAX);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      t2_count_ff <= T2_RST_VAL;
    end else if (t2_hold) begin
      t2_count_ff <= t2_reload;
    end else if (t2_wrap) begin
      t2_count_ff <= t2_reload;
    end else if (t2_run && t2_tick) begin
      t2_count_ff <= t2_count_ff + 16'h0001;
    end
  end

  // sticky request; a new overflow beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      t2_irq_ff <= 1'b0;
    end else if (t2_wrap) begin
      t2_irq_ff <= 1'b1;
    end else if (t2_irq_clear) begin
      t2_irq_ff <= 1'b0;
    end
  end

  // one-cycle abort, far inside the deadline; engine drops its transfer on it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comm_abort_ff <= 1'b0;
    end else begin
      comm_abort_ff <= t2_wrap && scl_low_timeout_enable;
    end
  end

  // ----------------------------------------------------------------
  // bus-free detection
  // ----------------------------------------------------------------
  logic [3:0] free_cnt_ff;
  smt_bus_t   bus_st_ff;
  smt_bus_t   nxt_bus_st;
  logic       bus_free_ff;
  logic       start_go_ff;
  logic       free_hit;

  // no src_tick, no count: slave-only parts still need the clock source
  always_ff @(posedge core_clk) begin
    if (srst) begin
      free_cnt_ff <= FREE_ZERO;
    end else if (!(scl_s && sda_s)) begin
      free_cnt_ff <= FREE_ZERO;
    end else if (src_tick && (free_cnt_ff <= FREE_LIMIT)) begin
      free_cnt_ff <= free_cnt_ff + FREE_ONE;
    end
  end

  assign free_hit = bus_free_timeout_enable && (free_cnt_ff > FREE_LIMIT);

  always_comb begin
    nxt_bus_st = bus_st_ff;
    case (bus_st_ff)
      BUS_BUSY: begin
        if (free_hit || stop_seen) begin
          nxt_bus_st = BUS_FREE;
        end
      end
      BUS_FREE: begin
        if (start_seen || !scl_s || start_go_ff) begin
          nxt_bus_st = BUS_BUSY;
        end
      end
      default: nxt_bus_st = BUS_BUSY;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_st_ff   <= BUS_BUSY;
      bus_free_ff <= 1'b0;
    end else begin
      bus_st_ff   <= nxt_bus_st;
      bus_free_ff <= (nxt_bus_st == BUS_FREE);
    end
  end

  // start fires on the edge the bus becomes free, or at once if already free
  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_go_ff <= 1'b0;
    end else begin
      start_go_ff <= start_pending && !start_go_ff && (nxt_bus_st == BUS_FREE);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign scl_o      = scl_o_ff;
  assign scl_oe_n   = scl_oe_n_ff;
  assign scl_rise   = scl_rise_ff;
  assign t2_count   = t2_count_ff;
  assign t2_irq     = t2_irq_ff;
  assign comm_abort = comm_abort_ff;
  assign bus_free   = bus_free_ff;
  assign start_go   = start_go_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  never_drive_high_a: assert property (
    @(posedge core_clk) disable iff (srst) !scl_oe_n |-> !scl_o)
    else $error("scl driven high");

  rise_report_a: assert property (
    @(posedge core_clk) disable iff (srst) scl_s && !scl_d_ff |=> scl_rise)
    else $error("scl rise not reported");

  reload_high_a: assert property (
    @(posedge core_clk) disable iff (srst)
    scl_low_timeout_enable && scl_s |=> t2_count == $past(t2_reload))
    else $error("timer 2 not reloaded while scl high");

  irq_overflow_a: assert property (
    @(posedge core_clk) disable iff (srst) t2_wrap |=> t2_irq && t2_count == $past(t2_reload))
    else $error("overflow did not raise interrupt");

  abort_latency_a: assert property (
    @(posedge core_clk) disable iff (srst)
    t2_wrap && scl_low_timeout_enable |=> comm_abort ##1 !comm_abort && scl_oe_n)
    else $error("abort not issued within deadline");

  abort_bound_a: assert property (
    @(posedge core_clk) disable iff (srst)
    comm_abort |-> $past(t2_wrap) && $past(scl_low_timeout_enable) && (ABORT_MAX_CYC >= 1))
    else $error("abort without an enabled scl-low timeout");

  free_timeout_a: assert property (
    @(posedge core_clk) disable iff (srst)
    bus_free_timeout_enable && free_cnt_ff > FREE_LIMIT && !bus_free |=> bus_free || start_go)
    else $error("bus not freed after high timeout");

  free_needs_stop_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !bus_free_timeout_enable && !bus_free && !stop_seen |=> !bus_free)
    else $error("bus freed without stop");

  start_on_free_a: assert property (
    @(posedge core_clk) disable iff (srst)
    start_pending && !start_go && nxt_bus_st == BUS_FREE |=> start_go)
    else $error("pending start not issued");

  normal_count_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !scl_low_timeout_enable && t2_run && t2_tick && t2_count != T2_MAX
    |=> t2_count == $past(t2_count) + 16'h0001)
    else $error("timer 2 disturbed by scl with timeout off");

endmodule : smt_timeout_detect

//--- smt_timeout_detect_tb.sv
// smt_timeout_detect_tb: self-checking bench for the timeout detector
// assumes smt_bus_partner on the far side and pull-ups on both lines
`timescale 1ns/1ps
module smt_timeout_detect_tb;
  import smt_pkg::*;
  typedef struct packed {
    logic fte;
    logic pend;
    logic exp_free;
    logic exp_go;
  } smt_row_t;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        scl_w, sda_w, p_scl, p_sda;
  logic        tle = 1'b0, fte = 1'b0, t2_run = 1'b1, t2_tick = 1'b0, t2_irq_clear = 1'b0;
  logic [15:0] t2_reload = 16'hfff0;
  logic [15:0] t2_count;
  logic        src_tick = 1'b0, drive_low = 1'b0, pend = 1'b0;
  logic        scl_o, scl_oe_n, t2_irq, scl_rise, comm_abort, bus_free, start_go;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          rises      = 0;
  int          i, n;
  smt_row_t    rows [4] = '{'{1'b1, 1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b1, 1'b0},
                            '{1'b0, 1'b1, 1'b0, 1'b0}, '{1'b0, 1'b0, 1'b0, 1'b0}};

  always #10 core_clk = ~core_clk;
  // pull-ups: a line is low only while some party pulls it
  assign scl_w = !(p_scl || (!scl_oe_n && !scl_o));
  assign sda_w = !p_sda;
  always @(posedge core_clk) if (scl_rise === 1'b1) rises <= rises + 1;

  smt_bus_partner p (.scl_hold(p_scl), .sda_hold(p_sda));
  smt_timeout_detect #(.ABORT_MAX_CYC(4)) DUT (
    .core_clk(core_clk), .srst(srst), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .scl_low_timeout_enable(tle), .bus_free_timeout_enable(fte),
    .t2_run(t2_run), .t2_tick(t2_tick), .t2_reload(t2_reload), .t2_irq_clear(t2_irq_clear),
    .t2_count(t2_count), .t2_irq(t2_irq), .src_tick(src_tick), .scl_drive_low(drive_low),
    .start_pending(pend), .scl_rise(scl_rise), .comm_abort(comm_abort),
    .bus_free(bus_free), .start_go(start_go));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // one src_tick pulse every other cycle, as a clock source divider would
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge core_clk) src_tick <= 1'b1;
      @(posedge core_clk) src_tick <= 1'b0;
    end
  endtask : tick
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #300us;
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(3);
    srst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      // scl low clears any earlier free state
      p.hold_scl(1'b1);
      cyc(4);
      p.hold_scl(1'b0);
      fte  <= rows[i].fte;
      pend <= rows[i].pend;
      cyc(30);
      #1 check(16'(bus_free), 16'h0, "free without ticks");
      tick(10);
      cyc(2);
      #1 check(16'(bus_free), 16'h0, "free after 10 ticks");
      tick(1);
      cyc(1);
      #1 check(16'(bus_free), 16'(rows[i].exp_free), "free after 11 ticks");
      check(16'(start_go), 16'(rows[i].exp_go), "start on free");
    end
    fte  <= 1'b0;
    pend <= 1'b0;
    n = rises;
    p.clock_frame(4, 400);
    p.clock_frame(2, 0);
    cyc(6);
    check(16'(rises - n), 16'h6, "rises in stretched and plain frames");
    // ----------------------------------------------------------------
    // timer 2 as scl-low detector
    // ----------------------------------------------------------------
    tle     <= 1'b1;
    t2_tick <= 1'b1;
    cyc(5);
    #1 check(t2_count, 16'hfff0, "reload while scl high");
    // a new reload value must be followed while scl stays high
    t2_reload <= t2_reload + 16'h0004;
    cyc(1);
    drive_low <= 1'b1;
    cyc(1);
    #1 check(16'({scl_oe_n, scl_o}), 16'h0, "pulls scl low");
    check(t2_count, 16'hfff4, "reload follows new value");
    n = 0;
    while (t2_irq !== 1'b1 && n < 100) begin
      cyc(1);
      #1 n++;
    end
    check(16'(comm_abort), 16'h1, "abort with overflow");
    check(t2_count, 16'hfff4, "reload on overflow");
    cyc(1);
    #1 check(16'(scl_oe_n), 16'h1, "scl freed on abort");
    cyc(1);
    drive_low    <= 1'b0;
    t2_irq_clear <= 1'b1;
    cyc(1);
    t2_irq_clear <= 1'b0;
    cyc(1);
    #1 check(16'(t2_irq), 16'h0, "irq cleared");
    cyc(1);
    srst    <= 1'b1;
    t2_tick <= 1'b0;
    tle     <= 1'b0;
    cyc(3);
    srst <= 1'b0;
    #1 check(t2_count, 16'h0, "count after reset");
    check(16'({bus_free, start_go, comm_abort, scl_oe_n}), 16'h1, "outputs after reset");
    // timer in normal mode ignores a low scl
    p.hold_scl(1'b1);
    for (i = 0; i < 2; i++) begin
      // second pass: a stopped timer holds its value
      cyc(1);
      t2_run  <= 1'(i == 0);
      t2_tick <= 1'b1;
      cyc(5);
      t2_tick <= 1'b0;
      cyc(1);
      #1 check(t2_count, 16'h5, "normal counting");
    end
    check(16'(comm_abort), 16'h0, "no abort when disabled");
    p.hold_scl(1'b0);
    pend <= 1'b1;
    cyc(6);
    p.hold_sda(1'b1);
    cyc(6);
    p.hold_sda(1'b0);
    n = 0;
    while (bus_free !== 1'b1 && n < 20) begin
      cyc(1);
      #1 n++;
    end
    check(16'({bus_free, start_go}), 16'h3, "stop frees bus");
    cyc(1);
    #1 check(16'({bus_free, start_go}), 16'h0, "free ends after start");
    final_report();
  end
endmodule : smt_timeout_detect_tb
